/* File: rtl/ptoc_noise_filter.sv */
// Pulse rejection filter for the serial clock and data inputs
`default_nettype none
module ptoc_noise_filter #(
	parameter int         WIDTH  = 2,
	parameter int         CYCLES = ptoc_pkg::FILTER_CYCLES,
	parameter logic [1:0] IDLE   = 2'h3
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Raw and filtered levels
	input  wire logic [WIDTH-1:0] raw_in,
	output logic      [WIDTH-1:0] filt_out
);
	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [WIDTH-1:0]         filt;
		logic [WIDTH-1:0][CW-1:0] cnt;
	} ptoc_filter_state_t;

	ptoc_filter_state_t st;
	ptoc_filter_state_t next_st;

	if (WIDTH != 2 || CYCLES < 1) begin : g_check
		$error("ptoc_noise_filter: WIDTH must be 2 and CYCLES at least 1");
	end

	// A new level is taken only after it has held for CYCLES clocks
	always_comb begin
		next_st = st;
		for (int i = 0; i < WIDTH; i++) begin
			if (raw_in[i] == st.filt[i]) begin
				next_st.cnt[i] = '0;
			end else if (st.cnt[i] == CW'(CYCLES - 1)) begin
				next_st.filt[i] = raw_in[i];
				next_st.cnt[i]  = '0;
			end else begin
				next_st.cnt[i] = st.cnt[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.filt <= IDLE;
			st.cnt  <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign filt_out = st.filt;
endmodule : ptoc_noise_filter
`default_nettype wire

/* File: rtl/ptoc_pkg.sv */
// Shared constants for the port timer option and configuration block
`default_nettype none
package ptoc_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int FILTER_NS     = 130;
	localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_PERIOD_NS = 5000;
	localparam int OSC_CYCLES    = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int INIT_TIME_NS  = 10000;
	localparam int INIT_CYCLES   = INIT_TIME_NS / CLK_PERIOD_NS;
	localparam int UNIT_SHORT    = 1;
	localparam int UNIT_LONG     = 64;
	// Command codes from the serial engine
	localparam logic [3:0] CMD_DEFAULT = 4'h5;
	localparam logic [3:0] CMD_SCALE   = 4'h6;
	localparam logic [3:0] CMD_TIMER0  = 4'h8;
	localparam logic [3:0] CMD_TIMER3  = 4'hB;
	// Register byte offsets
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_SCALE   = 8'h04;
	localparam logic [7:0] REG_DEFAULT = 8'h08;
	localparam logic [7:0] REG_START   = 8'h0C;
	localparam logic [7:0] REG_TIMER0  = 8'h10;
	localparam logic [7:0] REG_TIMER3  = 8'h1C;
	localparam logic [7:0] REG_CONTROL = 8'h20;
	// Reset values
	localparam logic [7:0] SCALE_RST   = 8'hFF;
	localparam logic [7:0] TIMER_RST   = 8'h00;
	localparam logic [3:0] DEFAULT_RST = 4'h0;
	localparam logic [3:0] START_RST   = 4'h0;
	// Status fields
	localparam int ST_INIT_DONE = 0;
	localparam int ST_GATE      = 1;
	localparam int ST_RUN_LSB   = 4;
	localparam int ST_OUT_LSB   = 8;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {PH_INIT, PH_STANDBY} ptoc_phase_t;
endpackage : ptoc_pkg
`default_nettype wire

/* File: rtl/ptoc_top.sv */
// Delayed-inversion timers, power-on window and build options of the port expander
// Function
// - Ignore serial commands until initialization ends
// - After initialization: standby, nothing pending
// - Reject serial input pulses under 130 ns
// - Slave address holds three option select bits
// - Timebase: internal 5 us oscillator or pin
// - Scale bit picks short or long unit
// - Shared pin: timer gate or reset input
// - Shared pin: external clock or pulldown output
// - Option one: power-up, gate edge, start bit
// - Per-port option; option two: start bit only
// - Scale setting command 0110, default FFH
// - Port timer settings 1000-1011, default 00H
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`default_nettype none
module ptoc_top #(
	parameter int         ADDR_W       = 8,
	parameter logic [3:0] ADDR_FIXED   = 4'h5, // Arbitrary fixed address bits
	parameter logic [2:0] ADDR_SELECT  = 3'h0,
	parameter bit         EXT_TIMEBASE = 1'b0,
	parameter bit         DOUBLE_UNIT  = 1'b0,
	parameter bit         PIN1_RESET   = 1'b0,
	parameter bit         PIN2_CLOCK   = 1'b1,
	parameter logic [3:0] START_BIT_ONLY = 4'h0,
	parameter int         INIT_CYCLES  = ptoc_pkg::INIT_CYCLES,
	parameter int         OSC_CYCLES   = ptoc_pkg::OSC_CYCLES
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Serial pins and filtered levels
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   scl_filtered,
	output logic                   sda_filtered,
	// Commands from the serial engine
	input  wire logic              cmd_valid,
	input  wire logic [3:0]        cmd_code,
	input  wire logic [7:0]        cmd_data,
	output logic                   cmd_ready,
	// Shared pins
	input  wire logic              gate_or_reset_pin,
	input  wire logic              ext_clock_pin,
	output logic                   bus_pulldown_control,
	output logic                   bus_pulldown_oe_n,
	// Status and timed ports
	output logic [6:0]             slave_address,
	output logic                   init_done,
	output logic                   timed_output_port0,
	output logic                   timed_output_port1,
	output logic                   timed_output_port2,
	output logic                   timed_output_port3
);
	localparam int IW = $clog2(INIT_CYCLES + 1);
	localparam int OW = $clog2(OSC_CYCLES + 1);

	typedef struct packed {
		ptoc_pkg::ptoc_phase_t phase;
		logic [IW-1:0]         init_cnt;
		logic [OW-1:0]         osc_cnt;
		logic                  ext_prev;
		logic                  tick;
		logic                  gate_prev;
		logic [3:0]            start_prev;
		logic [7:0]            scale;
		logic [3:0]            dflt;
		logic [3:0]            start_bits;
		logic [3:0][7:0]       tset;
		logic [3:0][10:0]      tcnt;
		logic [3:0]            run;
		logic [3:0]            inv;
		logic [3:0]            dout;
		logic                  pd_low;
		logic                  pd_out;
		logic                  pd_oe_n;
		logic [6:0]            saddr;
		logic                  cmd_ready;
		logic                  aw_got;
		logic [7:0]            aw_addr;
		logic                  w_got;
		logic [7:0]            wbyte;
		logic                  wlane;
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} ptoc_top_state_t;

	ptoc_top_state_t st;
	ptoc_top_state_t next_st;
	logic [1:0]      filt;
	logic            timer_gate_pin;
	logic            active_low_reset_pin;

	if (ADDR_W < 6 || INIT_CYCLES < 1 || OSC_CYCLES < 2 || (EXT_TIMEBASE && !PIN2_CLOCK))
	begin : g_check
		$error("ptoc_top: parameter values not supported");
	end

	// Serial input filter
	ptoc_noise_filter #(
		.WIDTH  (2),
		.CYCLES (ptoc_pkg::FILTER_CYCLES),
		.IDLE   (2'h3)
	) u_filter (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.raw_in   ({scl_in, sda_in}),
		.filt_out (filt)
	);

	// Shared pin one serves one function only
	assign timer_gate_pin       = PIN1_RESET ? 1'b0 : gate_or_reset_pin;
	assign active_low_reset_pin = PIN1_RESET ? gate_or_reset_pin : 1'b1;

	// Delay units: highest marked bit position plus one
	function automatic logic [3:0] units_of(input logic [7:0] sel);
		logic [3:0] u;
		u = 4'h0;
		for (int b = 0; b < 8; b++) begin
			if (sel[b]) begin
				u = 4'(b + 1);
			end
		end
		return u;
	endfunction : units_of

	// Base ticks for a port from its setting and scale bit
	function automatic logic [10:0] ticks_of(input logic [7:0] sel, input logic short_unit);
		logic [10:0] unit;
		unit = short_unit ? 11'(ptoc_pkg::UNIT_SHORT) : 11'(ptoc_pkg::UNIT_LONG);
		if (DOUBLE_UNIT) begin
			unit = unit << 1;
		end
		return 11'(units_of(sel) * unit);
	endfunction : ticks_of

	function automatic logic [31:0] read_reg(input ptoc_top_state_t s, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == ptoc_pkg::REG_STATUS) begin
			d[ptoc_pkg::ST_INIT_DONE] = (s.phase == ptoc_pkg::PH_STANDBY);
			d[ptoc_pkg::ST_GATE] = s.gate_prev;
			d[ptoc_pkg::ST_RUN_LSB +: 4] = s.run;
			d[ptoc_pkg::ST_OUT_LSB +: 4] = s.dout;
		end else if (a == ptoc_pkg::REG_SCALE) begin
			d[7:0] = s.scale;
		end else if (a == ptoc_pkg::REG_DEFAULT) begin
			d[3:0] = s.dflt;
		end else if (a == ptoc_pkg::REG_START) begin
			d[3:0] = s.start_bits;
		end else if (a >= ptoc_pkg::REG_TIMER0 && a <= ptoc_pkg::REG_TIMER3) begin
			d[7:0] = s.tset[a[3:2]];
		end else if (a == ptoc_pkg::REG_CONTROL) begin
			d[0] = s.pd_low;
		end
		return d;
	endfunction : read_reg

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= ptoc_pkg::REG_CONTROL;
	endfunction : mapped

	always_comb begin
		logic       power_start;
		logic       standby;
		logic       gate_rise;
		logic       sb_rise;
		logic       go;
		logic       do_write;
		logic [7:0] wa;
		power_start = 1'b0;
		standby     = 1'b0;
		gate_rise   = 1'b0;
		sb_rise     = 1'b0;
		go          = 1'b0;
		do_write    = 1'b0;
		wa          = st.aw_addr;
		next_st = st;

		// Power-on window
		unique case (st.phase)
			ptoc_pkg::PH_INIT: begin
				if (st.init_cnt == IW'(INIT_CYCLES - 1)) begin
					next_st.phase = ptoc_pkg::PH_STANDBY;
					power_start   = 1'b1;
				end else begin
					next_st.init_cnt = st.init_cnt + IW'(1);
				end
			end
			ptoc_pkg::PH_STANDBY: begin
				standby = 1'b1;
			end
		endcase
		next_st.cmd_ready = (next_st.phase == ptoc_pkg::PH_STANDBY);

		// Timebase
		next_st.ext_prev = ext_clock_pin;
		next_st.osc_cnt = (st.osc_cnt == OW'(OSC_CYCLES - 1)) ? '0 : st.osc_cnt + OW'(1);
		next_st.tick = EXT_TIMEBASE ? (ext_clock_pin & ~st.ext_prev)
			: (st.osc_cnt == OW'(OSC_CYCLES - 1));

		// Serial commands only once standby is reached
		if (standby && st.cmd_ready && cmd_valid) begin
			if (cmd_code == ptoc_pkg::CMD_SCALE) begin
				next_st.scale = cmd_data;
			end else if (cmd_code == ptoc_pkg::CMD_DEFAULT) begin
				next_st.dflt = cmd_data[3:0];
			end else if (cmd_code >= ptoc_pkg::CMD_TIMER0 && cmd_code <= ptoc_pkg::CMD_TIMER3) begin
				next_st.tset[cmd_code[1:0]] = cmd_data;
			end
		end

		// Write channel: address and data taken in either order
		if (st.awready && s_axi_awvalid) begin
			next_st.aw_got  = 1'b1;
			next_st.aw_addr = 8'(s_axi_awaddr);
		end
		if (st.wready && s_axi_wvalid) begin
			next_st.w_got = 1'b1;
			next_st.wbyte = s_axi_wdata[7:0];
			next_st.wlane = s_axi_wstrb[0];
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			do_write       = mapped(wa) && st.wlane;
			next_st.bvalid = 1'b1;
			next_st.bresp  = mapped(wa) ? ptoc_pkg::RESP_OKAY : ptoc_pkg::RESP_SLVERR;
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (do_write) begin
			if (wa == ptoc_pkg::REG_SCALE) begin
				next_st.scale = st.wbyte;
			end else if (wa == ptoc_pkg::REG_DEFAULT) begin
				next_st.dflt = st.wbyte[3:0];
			end else if (wa == ptoc_pkg::REG_START) begin
				next_st.start_bits = st.wbyte[3:0];
			end else if (wa >= ptoc_pkg::REG_TIMER0 && wa <= ptoc_pkg::REG_TIMER3) begin
				next_st.tset[wa[3:2]] = st.wbyte;
			end else if (wa == ptoc_pkg::REG_CONTROL) begin
				next_st.pd_low = st.wbyte[0];
			end
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready  = !next_st.w_got && !next_st.bvalid;

		// Read channel
		if (st.arready && s_axi_arvalid) begin
			next_st.arready = 1'b0;
			next_st.rvalid  = 1'b1;
			next_st.rdata   = mapped(8'(s_axi_araddr)) ? read_reg(st, 8'(s_axi_araddr)) : '0;
			next_st.rresp   = mapped(8'(s_axi_araddr)) ? ptoc_pkg::RESP_OKAY
				: ptoc_pkg::RESP_SLVERR;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid  = 1'b0;
			next_st.arready = 1'b1;
		end

		// Start conditions and delay timers
		next_st.gate_prev  = timer_gate_pin;
		next_st.start_prev = st.start_bits;
		gate_rise = standby && timer_gate_pin && !st.gate_prev;
		for (int i = 0; i < 4; i++) begin
			sb_rise = standby && st.start_bits[i] && !st.start_prev[i];
			if (START_BIT_ONLY[i]) begin
				go = sb_rise;
			end else begin
				go = (power_start && timer_gate_pin) || gate_rise
					|| (sb_rise && timer_gate_pin);
			end
			if (go) begin
				next_st.tcnt[i] = ticks_of(st.tset[i], st.scale[i]);
				next_st.run[i]  = (ticks_of(st.tset[i], st.scale[i]) != 11'h000);
				next_st.inv[i]  = 1'b0;
			end else if (st.run[i] && st.tick) begin
				if (st.tcnt[i] == 11'h001) begin
					next_st.run[i] = 1'b0;
					next_st.inv[i] = 1'b1;
				end else begin
					next_st.tcnt[i] = st.tcnt[i] - 11'h001;
				end
			end
		end

		// Reset function of the shared pin stops the timers
		if (!active_low_reset_pin) begin
			next_st.run = '0;
			next_st.inv = '0;
		end
		next_st.dout = next_st.dflt ^ next_st.inv;

		// Shared pin two: pulldown output only when not a clock input
		next_st.pd_out  = PIN2_CLOCK ? 1'b1 : !next_st.pd_low;
		next_st.pd_oe_n = PIN2_CLOCK;
		next_st.saddr   = {ADDR_FIXED, ADDR_SELECT};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st            <= '0;
			st.phase      <= ptoc_pkg::PH_INIT;
			st.scale      <= ptoc_pkg::SCALE_RST;
			st.dflt       <= ptoc_pkg::DEFAULT_RST;
			st.start_bits <= ptoc_pkg::START_RST;
			st.tset       <= {4{ptoc_pkg::TIMER_RST}};
			st.pd_out     <= 1'b1;
			st.pd_oe_n    <= 1'b1;
			st.awready    <= 1'b1;
			st.wready     <= 1'b1;
			st.arready    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready        = st.awready;
	assign s_axi_wready         = st.wready;
	assign s_axi_bvalid         = st.bvalid;
	assign s_axi_bresp          = st.bresp;
	assign s_axi_arready        = st.arready;
	assign s_axi_rvalid         = st.rvalid;
	assign s_axi_rdata          = st.rdata;
	assign s_axi_rresp          = st.rresp;
	assign scl_filtered         = filt[1];
	assign sda_filtered         = filt[0];
	assign cmd_ready            = st.cmd_ready;
	assign bus_pulldown_control = st.pd_out;
	assign bus_pulldown_oe_n    = st.pd_oe_n;
	assign slave_address        = st.saddr;
	assign init_done            = st.phase == ptoc_pkg::PH_STANDBY;
	assign timed_output_port0   = st.dout[0];
	assign timed_output_port1   = st.dout[1];
	assign timed_output_port2   = st.dout[2];
	assign timed_output_port3   = st.dout[3];
endmodule : ptoc_top
`default_nettype wire

/* File: verification/ptoc_checker.sv */
// Assertion checker for the port timer option block
`default_nettype none
module ptoc_checker #(
	parameter int         INIT_CYCLES = 20,
	parameter logic [2:0] ADDR_SELECT = 3'h0,
	parameter bit         PIN2_CLOCK  = 1'b1
) (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Serial pins
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       scl_filtered,
	input wire logic       sda_filtered,
	// Status
	input wire logic       cmd_ready,
	input wire logic       init_done,
	input wire logic [6:0] slave_address,
	input wire logic       bus_pulldown_oe_n
);
	logic [11:0] cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 12'h000;
		end else if (cnt != 12'hFFF) begin
			cnt <= cnt + 12'h001;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	init_gate_a: assert property (!init_done |-> !cmd_ready)
		else $error("command port open during init");
	init_time_a: assert property (
		$rose(init_done) |-> cnt == 12'(INIT_CYCLES))
		else $error("init window length wrong");
	standby_a: assert property (init_done |-> cmd_ready)
		else $error("not ready in standby");
	init_hold_a: assert property (init_done |=> init_done)
		else $error("standby left without reset");
	sda_filt_a: assert property (
		$changed(sda_filtered) |-> $past(sda_in, 2) == sda_filtered
			&& $past(sda_in, 32) == sda_filtered)
		else $error("short pulse passed on data");
	scl_filt_a: assert property (
		$changed(scl_filtered) |-> $past(scl_in, 2) == scl_filtered
			&& $past(scl_in, 32) == scl_filtered)
		else $error("short pulse passed on clock");
	addr_sel_a: assert property (init_done |-> slave_address[2:0] == ADDR_SELECT)
		else $error("address select bits wrong");
	pin_clock_a: assert property (PIN2_CLOCK |-> bus_pulldown_oe_n)
		else $error("pulldown driven in clock mode");
endmodule : ptoc_checker
bind ptoc_top ptoc_checker #(
	.INIT_CYCLES(INIT_CYCLES), .ADDR_SELECT(ADDR_SELECT), .PIN2_CLOCK(PIN2_CLOCK)
) i_ptoc_checker (
	.aclk(aclk), .aresetn(aresetn), .scl_in(scl_in), .sda_in(sda_in),
	.scl_filtered(scl_filtered), .sda_filtered(sda_filtered), .cmd_ready(cmd_ready),
	.init_done(init_done), .slave_address(slave_address), .bus_pulldown_oe_n(bus_pulldown_oe_n)
);
`default_nettype wire

/* File: verification/ptoc_serial_model.sv */
// Serial engine and timer gate model facing the block
`default_nettype none
module ptoc_serial_model (
	// Clock
	input  wire logic  aclk,
	// Command port
	input  wire logic  cmd_ready,
	output logic       cmd_valid,
	output logic [3:0] cmd_code,
	output logic [7:0] cmd_data,
	// Timer gate
	output logic       gate_or_reset_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 4'h0;
		cmd_data = 8'h00;
		gate_or_reset_pin = 1'b1;
	end
	// Payload held steady until the taking edge has passed
	task automatic issue(input logic [3:0] code, input logic [7:0] data, input bit wait_rdy);
		cmd_code <= code;
		cmd_data <= data;
		cmd_valid <= 1'b1;
		do begin
			@(posedge aclk);
		end while (wait_rdy && !cmd_ready);
		cmd_valid <= 1'b0;
		@(posedge aclk);
	endtask : issue
	task automatic set_gate(input logic lvl);
		gate_or_reset_pin <= lvl;
		@(posedge aclk);
	endtask : set_gate
endmodule : ptoc_serial_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the port timer option block
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awv, awrd, wv, wrd, bv, br, arv, arrd, rv, rr;
	logic        scl, sda, sclf, sdaf, cv, crdy, gate, pd, pdoe, idone, eclk;
	logic [7:0]  awa, ara, cd;
	logic [31:0] wd, rdat;
	logic [1:0]  bresp, rresp;
	logic [3:0]  cc, dout, wstb;
	logic [6:0]  sadr;
	int          error_cnt = 0;
	int          num_checks = 0;
	ptoc_top #(.ADDR_SELECT(3'h5), .START_BIT_ONLY(4'h8), .INIT_CYCLES(20), .OSC_CYCLES(4)) i_ptoc_top (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awrd), .s_axi_wdata(wd), .s_axi_wstrb(wstb), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrd), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .scl_in(scl), .sda_in(sda),
		.scl_filtered(sclf), .sda_filtered(sdaf), .cmd_valid(cv), .cmd_code(cc), .cmd_data(cd),
		.cmd_ready(crdy), .gate_or_reset_pin(gate), .ext_clock_pin(eclk),
		.bus_pulldown_control(pd), .bus_pulldown_oe_n(pdoe), .slave_address(sadr),
		.init_done(idone), .timed_output_port0(dout[0]), .timed_output_port1(dout[1]),
		.timed_output_port2(dout[2]), .timed_output_port3(dout[3])
	);
	ptoc_serial_model i_ptoc_serial_model (
		.aclk(aclk), .cmd_ready(crdy), .cmd_valid(cv), .cmd_code(cc), .cmd_data(cd),
		.gate_or_reset_pin(gate)
	);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awrd) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (!bv);
		chk(bresp, er);
		br <= 1'b0;
		@(posedge aclk);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
			if (arv && arrd) arv <= 1'b0;
		end while (!rv);
		d = rdat;
		r = rresp;
		rr <= 1'b0;
		@(posedge aclk);
	endtask : axr
	task automatic t_init();
		logic [31:0] v;
		logic [1:0]  r;
		i_ptoc_serial_model.issue(ptoc_pkg::CMD_SCALE, 8'h00, 1'b0);
		chk({idone, crdy}, 32'h0);
		for (int n = 0; n < 100 && idone !== 1'b1; n++) cyc(1);
		chk({idone, crdy}, 32'h3);
		chk(sadr, {4'h5, 3'h5});
		axr(ptoc_pkg::REG_SCALE, v, r);
		chk(v, 32'hFF);
		for (int k = 0; k < 4; k++) begin
			axr(ptoc_pkg::REG_TIMER0 + 8'(4 * k), v, r);
			chk(v, 32'h0);
		end
		axr(ptoc_pkg::REG_STATUS, v, r);
		chk(v[11:0], 32'h003);
		$display("init test done");
	endtask : t_init
	task automatic t_cmds();
		logic [31:0] v;
		logic [1:0]  r;
		for (int k = 0; k < 4; k++) begin
			i_ptoc_serial_model.issue(ptoc_pkg::CMD_TIMER0 + 4'(k), 8'(8'h04 << k), 1'b1);
			axr(ptoc_pkg::REG_TIMER0 + 8'(4 * k), v, r);
			chk(v, 32'(8'h04 << k));
		end
		i_ptoc_serial_model.issue(ptoc_pkg::CMD_SCALE, 8'hFE, 1'b1);
		axr(ptoc_pkg::REG_SCALE, v, r);
		chk(v, 32'hFE);
		$display("command test done");
	endtask : t_cmds
	task automatic t_timer();
		i_ptoc_serial_model.issue(ptoc_pkg::CMD_TIMER0, 8'h01, 1'b1);
		axw(ptoc_pkg::REG_START, 32'h0, ptoc_pkg::RESP_OKAY);
		axw(ptoc_pkg::REG_START, 32'h1, ptoc_pkg::RESP_OKAY);
		cyc(240);
		chk(dout[0], 32'h0);
		cyc(22);
		chk(dout[0], 32'h1);
		i_ptoc_serial_model.issue(ptoc_pkg::CMD_DEFAULT, 8'h02, 1'b1);
		axw(ptoc_pkg::REG_START, 32'h3, ptoc_pkg::RESP_OKAY);
		cyc(6);
		chk(dout[1], 32'h1);
		cyc(16);
		chk(dout[1], 32'h0);
		$display("timer test done");
	endtask : t_timer
	task automatic t_gate();
		i_ptoc_serial_model.set_gate(1'b0);
		cyc(2);
		i_ptoc_serial_model.set_gate(1'b1);
		cyc(3);
		chk(dout[2], 32'h0);
		cyc(35);
		chk(dout[3:2], 32'h1);
		i_ptoc_serial_model.set_gate(1'b0);
		axw(ptoc_pkg::REG_START, 32'hF, ptoc_pkg::RESP_OKAY);
		cyc(3);
		chk(dout[2], 32'h1);
		cyc(30);
		chk(dout[3], 32'h1);
		$display("gate test done");
	endtask : t_gate
	task automatic t_misc();
		logic [31:0] v;
		logic [1:0]  r;
		axr(8'h40, v, r);
		chk(r, ptoc_pkg::RESP_SLVERR);
		axw(8'h24, 32'h1, ptoc_pkg::RESP_SLVERR);
		axw(ptoc_pkg::REG_CONTROL, 32'h1, ptoc_pkg::RESP_OKAY);
		chk({pd, pdoe}, 32'h3);
		wstb <= 4'hE;
		axw(ptoc_pkg::REG_SCALE, 32'h0, ptoc_pkg::RESP_OKAY);
		wstb <= 4'hF;
		axr(ptoc_pkg::REG_SCALE, v, r);
		chk(v, 32'hFE);
		scl <= 1'b0;
		sda <= 1'b0;
		cyc(32);
		scl <= 1'b1;
		sda <= 1'b1;
		cyc(3);
		chk({sclf, sdaf}, 32'h3);
		scl <= 1'b0;
		sda <= 1'b0;
		cyc(33);
		chk({sclf, sdaf}, 32'h3);
		cyc(1);
		chk({sclf, sdaf}, 32'h0);
		scl <= 1'b1;
		sda <= 1'b1;
		cyc(40);
		$display("bus and filter test done");
	endtask : t_misc
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
	initial begin
		aresetn = 1'b0;
		{awv, wv, br, arv, rr} = 5'h00;
		{awa, ara, wd} = 48'h0;
		{scl, sda} = 2'h3;
		wstb = 4'hF;
		eclk = 1'b0;
		cyc(6);
		aresetn <= 1'b1;
		t_init();
		t_cmds();
		t_timer();
		t_gate();
		t_misc();
		conclude();
	end
endmodule : testbench
`default_nettype wire
